// [sgx_regs.svh]
// Timing and layout constants for the serial pin expander
`ifndef SGX_REGS_SVH
`define SGX_REGS_SVH
`define SGX_BITS_PER_STAGE 8
`define SGX_MAX_STAGES 8
`define SGX_CLK_PERIOD_NS 4
`define SGX_SHIFT_HALF_NS 40
`define SGX_SHIFT_HALF_CYC ((`SGX_SHIFT_HALF_NS + `SGX_CLK_PERIOD_NS - 1) / `SGX_CLK_PERIOD_NS)
`define SGX_LOAD_CYC 2
`endif

// [sgx_pkg.sv]
// Types for the serial pin expander
package sgx_pkg;
	typedef enum logic [1:0] {
		SGX_IDLE = 2'b00,
		SGX_SHIFT = 2'b01,
		SGX_LOAD = 2'b10
	} sgx_state_e;
endpackage : sgx_pkg

// [sgx_sync.sv]
// Two-flop synchroniser for a single level
`timescale 1ns/1ps
module sgx_sync (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_d,
	output logic o_q
);
	logic meta_reg;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_reg <= 1'b0;
			o_q <= 1'b0;
		end else begin
			meta_reg <= i_d;
			o_q <= meta_reg;
		end
	end
endmodule : sgx_sync

// [sgx_expander.sv]
// Serial pin expander controller driving an external shift register chain
// How it works
// - Pins are added eight at a time, one external register each.
// - Chain length is one to eight registers, at most sixty-four pins.
// - Outputs leave through serial-in registers, inputs come via parallel-in ones.
// - Drives data out, load, reset_n and shift clock; reads data in.
// - Reset_n stays low until the start bit is set.
// - Load strobe stays low until the start bit is set.
// - Shift clock stays still until the start bit is set.
`timescale 1ns/1ps
`include "sgx_regs.svh"
module sgx_expander #(
	parameter int STAGES = `SGX_MAX_STAGES
) (
	input wire logic I_CLK,
	input wire logic I_RESETN,
	input wire logic I_START,
	input wire logic [STAGES*`SGX_BITS_PER_STAGE-1:0] I_OUT_DATA,
	output logic [STAGES*`SGX_BITS_PER_STAGE-1:0] O_IN_DATA,
	output logic O_FRAME_DONE,
	input wire logic I_EXPANDER_SERIAL_IN,
	output logic O_EXPANDER_SERIAL_OUT,
	output logic O_EXPANDER_LOAD_STROBE,
	output logic O_EXPANDER_RESET_N,
	output logic O_EXPANDER_SHIFT_CLOCK
);
	localparam int NBITS = STAGES * `SGX_BITS_PER_STAGE;
	localparam int HALF = `SGX_SHIFT_HALF_CYC;
	localparam int HALF_M1 = (HALF < 1) ? 0 : HALF - 1;

	// Refuse lengths and timings that the counters below cannot serve
	if (STAGES < 1 || STAGES > `SGX_MAX_STAGES) begin : g_bad_stages
		$error("Chain length must be one to eight registers");
	end
	if (HALF < 1 || HALF > 256) begin : g_bad_half
		$error("Shift half period must be one to 256 clocks");
	end
	if (`SGX_LOAD_CYC < 1 || `SGX_LOAD_CYC > 127) begin : g_bad_load
		$error("Load strobe must last one to 127 half periods");
	end

	sgx_pkg::sgx_state_e state_reg;
	logic started_reg;
	logic [7:0] half_cnt_reg;
	logic [6:0] bit_cnt_reg;
	logic [NBITS-1:0] out_sh_reg;
	logic [NBITS-1:0] in_sh_reg;
	logic sclk_reg;
	logic load_reg;
	logic dout_reg;
	logic din_sync;
	logic half_tick;
	sgx_pkg::sgx_state_e state_next;
	logic in_idle;
	logic in_shift;
	logic in_load;
	logic frame_begin;
	logic sclk_rise;
	logic sclk_fall;
	logic last_bit;
	logic shift_end;
	logic load_end;

	// Pin input crosses from the board, so it is synchronised first
	sgx_sync u_din_sync (
		.i_clk(I_CLK),
		.i_resetn(I_RESETN),
		.i_d(I_EXPANDER_SERIAL_IN),
		.o_q(din_sync)
	);

	assign half_tick = (half_cnt_reg == 8'(HALF_M1));

	// Start is sticky; only a system reset returns the chain to reset
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			started_reg <= 1'b0;
		end else if (I_START) begin
			started_reg <= 1'b1;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			half_cnt_reg <= 8'h00;
		end else if (state_reg == sgx_pkg::SGX_IDLE || half_tick) begin
			half_cnt_reg <= 8'h00;
		end else begin
			half_cnt_reg <= half_cnt_reg + 8'h01;
		end
	end

	// State decodes shared by the registers below
	always_comb begin
		in_idle = 1'b0;
		in_shift = 1'b0;
		in_load = 1'b0;
		case (state_reg)
			sgx_pkg::SGX_IDLE: begin
				in_idle = 1'b1;
			end
			sgx_pkg::SGX_SHIFT: begin
				in_shift = 1'b1;
			end
			sgx_pkg::SGX_LOAD: begin
				in_load = 1'b1;
			end
			default: begin
				in_idle = 1'b0;
			end
		endcase
	end

	// Frame events
	assign frame_begin = in_idle && started_reg;
	assign sclk_rise = in_shift && half_tick && !sclk_reg;
	assign sclk_fall = in_shift && half_tick && sclk_reg;
	assign last_bit = (bit_cnt_reg == 7'(NBITS - 1));
	assign shift_end = sclk_fall && last_bit;
	assign load_end = in_load && half_tick && (bit_cnt_reg == 7'(`SGX_LOAD_CYC - 1));

	// Idle, shift every bit, then hold the load strobe
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sgx_pkg::SGX_IDLE: begin
				if (started_reg) begin
					state_next = sgx_pkg::SGX_SHIFT;
				end
			end
			sgx_pkg::SGX_SHIFT: begin
				if (shift_end) begin
					state_next = sgx_pkg::SGX_LOAD;
				end
			end
			sgx_pkg::SGX_LOAD: begin
				if (load_end) begin
					state_next = sgx_pkg::SGX_IDLE;
				end
			end
			default: begin
				state_next = sgx_pkg::SGX_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			state_reg <= sgx_pkg::SGX_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Counts shifted bits, then load half periods
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			bit_cnt_reg <= 7'h00;
		end else if (frame_begin || shift_end || load_end) begin
			bit_cnt_reg <= 7'h00;
		end else if (sclk_fall || (in_load && half_tick)) begin
			bit_cnt_reg <= bit_cnt_reg + 7'h01;
		end
	end

	// Idles low, so the chain sees no edge before start
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			sclk_reg <= 1'b0;
		end else if (in_idle) begin
			sclk_reg <= 1'b0;
		end else if (sclk_rise) begin
			sclk_reg <= 1'b1;
		end else if (sclk_fall) begin
			sclk_reg <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			load_reg <= 1'b0;
		end else if (in_idle || load_end) begin
			load_reg <= 1'b0;
		end else if (in_load) begin
			load_reg <= 1'b1;
		end
	end

	// Next bit set up at the fall, half a period before the chain takes it
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			dout_reg <= 1'b0;
		end else if (frame_begin) begin
			dout_reg <= I_OUT_DATA[NBITS-1];
		end else if (sclk_fall && !last_bit) begin
			dout_reg <= out_sh_reg[NBITS-1];
		end
	end

	// Whole frame latched so the chain sees one coherent image
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			out_sh_reg <= '0;
		end else if (frame_begin) begin
			out_sh_reg <= I_OUT_DATA << 1;
		end else if (sclk_fall && !last_bit) begin
			out_sh_reg <= out_sh_reg << 1;
		end
	end

	// Sampled at the rise, before the chain moves its next bit out
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			in_sh_reg <= '0;
		end else if (sclk_rise) begin
			in_sh_reg <= {in_sh_reg[NBITS-2:0], din_sync};
		end
	end

	// Captured inputs published once per frame; 
	// the sampled bits lag the load by one frame, a known trade-off
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_IN_DATA <= '0;
			O_FRAME_DONE <= 1'b0;
		end else begin
			O_FRAME_DONE <= 1'b0;
			if (state_reg == sgx_pkg::SGX_LOAD && half_tick &&
				bit_cnt_reg == 7'(`SGX_LOAD_CYC - 1)) begin
				O_IN_DATA <= in_sh_reg;
				O_FRAME_DONE <= 1'b1;
			end
		end
	end

	assign O_EXPANDER_RESET_N = started_reg;
	assign O_EXPANDER_SHIFT_CLOCK = sclk_reg;
	assign O_EXPANDER_LOAD_STROBE = load_reg;
	assign O_EXPANDER_SERIAL_OUT = dout_reg;
endmodule : sgx_expander

// [sgx_expander_sva.sv]
// Port assertions for the pin expander
`timescale 1ns/1ps
module sgx_sva (
	input logic I_CLK,
	input logic I_RESETN,
	input logic I_START,
	input logic O_FRAME_DONE,
	input logic O_EXPANDER_SERIAL_OUT,
	input logic O_EXPANDER_LOAD_STROBE,
	input logic O_EXPANDER_RESET_N,
	input logic O_EXPANDER_SHIFT_CLOCK
);
	wire rn = O_EXPANDER_RESET_N;
	wire ld = O_EXPANDER_LOAD_STROBE;
	wire sc = O_EXPANDER_SHIFT_CLOCK;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RESETN);
	AST_HELD: assert property (!rn && !I_START |=> !rn) else $error("held");
	AST_FREE: assert property (I_START |=> rn) else $error("free");
	AST_LOW: assert property (!rn |-> !ld) else $error("load");
	AST_STILL: assert property (!rn |-> $stable(sc)) else $error("clock");
	AST_WIDTH: assert property ($rose(ld) |-> ##19 $fell(ld)) else $error("width");
	AST_DONE: assert property (O_FRAME_DONE |-> $fell(ld)) else $error("done");
	AST_HALF: assert property ($rose(sc) |-> ##10 $fell(sc)) else $error("half");
	AST_DATA: assert property ($rose(sc) |-> $stable(O_EXPANDER_SERIAL_OUT))
		else $error("data");
	AST_PULSE: assert property (O_FRAME_DONE |=> !O_FRAME_DONE)
		else $error("done pulse too long");
	AST_SETUP: assert property ($changed(O_EXPANDER_SERIAL_OUT) |-> !sc)
		else $error("data moved while clock high");
endmodule : sgx_sva
bind sgx_expander sgx_sva sgx_sva_i (
	.I_CLK(I_CLK),
	.I_RESETN(I_RESETN),
	.I_START(I_START),
	.O_FRAME_DONE(O_FRAME_DONE),
	.O_EXPANDER_SERIAL_OUT(O_EXPANDER_SERIAL_OUT),
	.O_EXPANDER_LOAD_STROBE(O_EXPANDER_LOAD_STROBE),
	.O_EXPANDER_RESET_N(O_EXPANDER_RESET_N),
	.O_EXPANDER_SHIFT_CLOCK(O_EXPANDER_SHIFT_CLOCK)
);

// [sgx_chain.sv]
// Output register looped back into an input register
`timescale 1ns/1ps
module sgx_chain (
	input logic i_sclk,
	input logic i_load,
	input logic i_reset_n,
	input logic i_din,
	output logic o_dout
);
	logic [7:0] out_reg = 8'h00;
	logic [7:0] in_reg = 8'h00;
	assign o_dout = in_reg[7];
	// Reset clears both; load loops one frame's outputs into the next frame's inputs
	always @(posedge i_sclk or posedge i_load or negedge i_reset_n) begin
		if (!i_reset_n) begin
			out_reg <= 8'h00;
			in_reg <= 8'h00;
		end else if (i_load) begin
			in_reg <= out_reg;
		end else begin
			out_reg <= {out_reg[6:0], i_din};
			in_reg <= in_reg << 1;
		end
	end
endmodule : sgx_chain

// [sgx_expander_bench.sv]
// Bench for the expander on a one-register chain
`timescale 1ns/1ps
module sgx_expander_bench;
	logic I_CLK = 1'h0, I_RESETN = 1'h0, I_START = 1'h0, I_EXPANDER_SERIAL_IN;
	logic O_FRAME_DONE, O_EXPANDER_SERIAL_OUT, O_EXPANDER_LOAD_STROBE;
	logic O_EXPANDER_RESET_N, O_EXPANDER_SHIFT_CLOCK;
	logic [7:0] I_OUT_DATA = 8'h00, O_IN_DATA, prev = 8'h00, q[$];
	int fails = 0, total_checks = 0;
	always #2 I_CLK = ~I_CLK;
	sgx_expander #(.STAGES(1)) sgx_expander_i (
		.I_CLK(I_CLK),
		.I_RESETN(I_RESETN),
		.I_START(I_START),
		.I_OUT_DATA(I_OUT_DATA),
		.O_IN_DATA(O_IN_DATA),
		.O_FRAME_DONE(O_FRAME_DONE),
		.I_EXPANDER_SERIAL_IN(I_EXPANDER_SERIAL_IN),
		.O_EXPANDER_SERIAL_OUT(O_EXPANDER_SERIAL_OUT),
		.O_EXPANDER_LOAD_STROBE(O_EXPANDER_LOAD_STROBE),
		.O_EXPANDER_RESET_N(O_EXPANDER_RESET_N),
		.O_EXPANDER_SHIFT_CLOCK(O_EXPANDER_SHIFT_CLOCK)
	);
	sgx_chain sgx_chain_i (.i_sclk(O_EXPANDER_SHIFT_CLOCK), .i_load(O_EXPANDER_LOAD_STROBE),
		.i_reset_n(O_EXPANDER_RESET_N), .i_din(O_EXPANDER_SERIAL_OUT),
		.o_dout(I_EXPANDER_SERIAL_IN));
	task give_verdict;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	task check_bit(input string name, input logic seen, input logic want);
		total_checks++;
		if (seen !== want) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, want, seen);
		end
	endtask : check_bit
	// Each frame but the first of a pass returns the image sent one frame earlier through the loop-back
	always @(negedge I_CLK) if (O_FRAME_DONE === 1'h1) begin
		total_checks++;
		if (q.size() == 0) begin
			fails++;
			$display("mismatch O_IN_DATA expected none seen %h", O_IN_DATA);
		end else begin
			prev = q.pop_front();
			if (O_IN_DATA !== prev) begin
				fails++;
				$display("mismatch O_IN_DATA expected %h seen %h", prev, O_IN_DATA);
			end
		end
	end
	// Two passes of about a thousand cycles each; ample slack before the limit
	initial begin
		#20000;
		fails++;
		give_verdict;
	end
	initial begin
		void'($urandom(17605));
		// Second pass drops reset during a load to show the chain held again
		repeat (2) begin
			#1 I_RESETN = 1'h0;
			I_START = 1'h0;
			q.delete();
			repeat (3) @(posedge I_CLK);
			#1 I_RESETN = 1'h1;
			repeat (40) @(posedge I_CLK);
			#1 check_bit("O_EXPANDER_RESET_N", O_EXPANDER_RESET_N, 1'h0);
			check_bit("O_EXPANDER_LOAD_STROBE", O_EXPANDER_LOAD_STROBE, 1'h0);
			check_bit("O_EXPANDER_SHIFT_CLOCK", O_EXPANDER_SHIFT_CLOCK, 1'h0);
			// Chain cleared by its reset, so the first frame reads zero
			q.push_back(8'h00);
			repeat (5) begin
				I_OUT_DATA = 8'($urandom);
				q.push_back(I_OUT_DATA);
				I_START = 1'h1;
				@(posedge O_EXPANDER_LOAD_STROBE);
				@(posedge I_CLK);
				#1 check_bit("O_EXPANDER_RESET_N", O_EXPANDER_RESET_N, 1'h1);
			end
			repeat (5) @(posedge I_CLK);
		end
		repeat (30) @(posedge I_CLK);
		give_verdict;
	end
endmodule : sgx_expander_bench
